// file: rtcp_pkg.sv
`default_nettype none

package rtcp_pkg;

    // ------------------------------------------------------------------
    // Period selection codes
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        RTCP_SEL_OFF   = 3'b000,
        RTCP_SEL_FIXED = 3'b001,
        RTCP_SEL_P2HZ  = 3'b010,
        RTCP_SEL_P1HZ  = 3'b011,
        RTCP_SEL_LSEC  = 3'b100,
        RTCP_SEL_LMIN  = 3'b101,
        RTCP_SEL_LHOUR = 3'b110,
        RTCP_SEL_LMON  = 3'b111
    } rtcp_sel_e;

    // ------------------------------------------------------------------
    // Control register 1 placement of the selection field
    // ------------------------------------------------------------------
    localparam logic [3:0] RTCP_CTRL1_OFFSET  = 4'hE;
    localparam int unsigned RTCP_SEL_LSB      = 0;
    localparam int unsigned RTCP_SEL_MSB      = 2;
    localparam logic [2:0] RTCP_SEL_RESET     = 3'h0;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int unsigned RTCP_CLK_PERIOD_NS = 10;
    localparam int unsigned RTCP_QUARTER_MS    = 250;
    localparam int unsigned RTCP_QUARTER_CYC   = RTCP_QUARTER_MS * 1000000 / RTCP_CLK_PERIOD_NS;
    localparam int unsigned RTCP_INC_DELAY_US  = 92;
    localparam int unsigned RTCP_INC_DELAY_CYC = RTCP_INC_DELAY_US * 1000 / RTCP_CLK_PERIOD_NS;
    localparam int unsigned RTCP_ADJ_NS        = 3784000;
    localparam int unsigned RTCP_ADJ_CYC       = RTCP_ADJ_NS / RTCP_CLK_PERIOD_NS;
    localparam int unsigned RTCP_ADJ_PERIOD_S  = 20;
    localparam logic [4:0]  RTCP_ADJ_LAST_S    = 5'(RTCP_ADJ_PERIOD_S - 1);
    localparam logic [1:0]  RTCP_LAST_QUARTER  = 2'h3;

endpackage : rtcp_pkg

`default_nettype wire

// file: rtcp_subsec.sv
`default_nettype none

module rtcp_subsec
    import rtcp_pkg::*;
#(
    parameter int unsigned CNT_W = 32
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             srst,
    // Control
    input  wire logic             restart,
    input  wire logic [CNT_W-1:0] len_m1,
    // Divider state
    output logic      [CNT_W-1:0] cnt,
    output logic      [1:0]       quarter
);

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic [1:0]       qtr;
    } rtcp_div_s;

    rtcp_div_s s_q;
    rtcp_div_s s_d;

    // ------------------------------------------------------------------
    // Quarter-second divider
    // ------------------------------------------------------------------
    // The length of each quarter is supplied per quarter, so the parent can
    // stretch or shrink a single quarter without any extra state here.
    always_comb begin
        s_d = s_q;
        if (restart) begin
            s_d.cnt = '0;
            s_d.qtr = '0;
        end else if (s_q.cnt >= len_m1) begin
            s_d.cnt = '0;
            s_d.qtr = s_q.qtr + 2'd1;
        end else begin
            s_d.cnt = s_q.cnt + CNT_W'(1);
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign cnt     = s_q.cnt;
    assign quarter = s_q.qtr;

endmodule : rtcp_subsec

`default_nettype wire

// file: rtcp_periodic.sv
// Contract
// - Three-bit select: off, low, pulse, level
// - Codes 010/011 give 2 Hz, 1 Hz squares
// - Codes 1xx: event per second/minute/hour/month
// - Events gated on seconds/minutes/hours zero, day one
// - Level event holds output low until flag cleared
// - Pulses locked to seconds counter increment
// - Pulse mode: increment 92 us after fall
// - Seconds write clears divider, drives output low
// - Level mode: increment coincides with falling edge
// - Adjustment alters pulse low phase every 20 s
// - Adjustment shifts level one-second period by 3.784 ms
// - Select field lives at bits 2:0 of 0xE
// - After reset with all zero, output high
// - Alarm and periodic requests ORed onto output
`default_nettype none

module rtcp_periodic
    import rtcp_pkg::*;
#(
    parameter int unsigned QUARTER_CYC   = RTCP_QUARTER_CYC,
    parameter int unsigned INC_DELAY_CYC = RTCP_INC_DELAY_CYC,
    parameter int unsigned ADJ_CYC       = RTCP_ADJ_CYC,
    parameter int unsigned CNT_W         = 32
) (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       srst,
    // Configuration from control register 1
    input  wire logic [2:0] period_sel,
    input  wire logic       weekly_alarm_enable,
    input  wire logic       daily_alarm_enable,
    // Alarm requests from the alarm matcher
    input  wire logic       alarm_w_match,
    input  wire logic       alarm_d_match,
    // Host accesses
    input  wire logic       flag_clear,
    input  wire logic       sec_write,
    // Time counter state reached by the coming increment
    input  wire logic       next_sec_zero,
    input  wire logic       next_min_zero,
    input  wire logic       next_hour_zero,
    input  wire logic       next_day_one,
    // Oscillation adjustment
    input  wire logic       adj_enable,
    input  wire logic       adj_lengthen,
    // Results
    output logic            sec_inc,
    output logic            periodic_event_flag,
    output logic            irq_out_n,
    output logic            irq_oe
);

    // ------------------------------------------------------------------
    // Mode decoding
    // ------------------------------------------------------------------
    function automatic logic is_level(input logic [2:0] sel);
        return sel[2];
    endfunction : is_level

    function automatic logic is_pulse(input logic [2:0] sel);
        return (sel == RTCP_SEL_P2HZ) || (sel == RTCP_SEL_P1HZ);
    endfunction : is_pulse

    typedef struct packed {
        logic       flag;
        logic       sec_inc;
        logic       irq_low;
        logic       irq_n;
        logic [4:0] sec20;
    } rtcp_state_s;

    rtcp_state_s s_q;
    rtcp_state_s s_d;

    logic [CNT_W-1:0] cnt;
    logic [1:0]       quarter;
    logic [CNT_W-1:0] len_m1;
    logic             wrap;
    logic             adj_slot;
    logic             level_ev;
    logic             flag_set;
    logic             alarm_any;
    rtcp_sel_e        sel;

    assign sel = rtcp_sel_e'(period_sel[RTCP_SEL_MSB:RTCP_SEL_LSB]);

    // ------------------------------------------------------------------
    // Sub-second timebase
    // ------------------------------------------------------------------
    // Only the first quarter of every twentieth second is resized, so the
    // correction lands in the low phase of both pulse rates and moves the
    // next level-mode edge by the same amount.
    assign adj_slot = adj_enable && (s_q.sec20 == '0) && (quarter == 2'd0);

    always_comb begin
        if (adj_slot && adj_lengthen) begin
            len_m1 = CNT_W'(QUARTER_CYC + ADJ_CYC - 1);
        end else if (adj_slot) begin
            len_m1 = CNT_W'(QUARTER_CYC - ADJ_CYC - 1);
        end else begin
            len_m1 = CNT_W'(QUARTER_CYC - 1);
        end
    end

    rtcp_subsec #(
        .CNT_W   (CNT_W)
    ) u_subsec (
        .clock   (clock),
        .srst    (srst),
        .restart (sec_write),
        .len_m1  (len_m1),
        .cnt     (cnt),
        .quarter (quarter)
    );

    assign wrap = !sec_write && (quarter == RTCP_LAST_QUARTER) && (cnt >= len_m1);

    // ------------------------------------------------------------------
    // Level-mode event selection
    // ------------------------------------------------------------------
    always_comb begin
        case (sel)
            RTCP_SEL_LSEC:  level_ev = 1'b1;
            RTCP_SEL_LMIN:  level_ev = next_sec_zero;
            RTCP_SEL_LHOUR: level_ev = next_sec_zero && next_min_zero;
            RTCP_SEL_LMON:  level_ev = next_sec_zero && next_min_zero
                                       && next_hour_zero && next_day_one;
            default:        level_ev = 1'b0;
        endcase
    end

    assign flag_set  = is_level(sel) && ((wrap && level_ev) || sec_write);
    assign alarm_any = (weekly_alarm_enable && alarm_w_match)
                       || (daily_alarm_enable && alarm_d_match);

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        // A new event in the same cycle as the host's clear keeps the flag.
        if (flag_set) begin
            s_d.flag = 1'b1;
        end else if (flag_clear) begin
            s_d.flag = 1'b0;
        end
        if (wrap) begin
            s_d.sec20 = (s_q.sec20 == RTCP_ADJ_LAST_S) ? 5'd0 : s_q.sec20 + 5'd1;
        end
        // Pulse modes delay the increment past the falling edge; the other
        // modes step the seconds exactly at the divider wrap.
        if (is_pulse(sel)) begin
            s_d.sec_inc = (quarter == 2'd0) && (cnt == CNT_W'(INC_DELAY_CYC))
                          && !sec_write;
        end else begin
            s_d.sec_inc = wrap;
        end
        case (sel)
            RTCP_SEL_OFF:   s_d.irq_low = 1'b0;
            RTCP_SEL_FIXED: s_d.irq_low = 1'b1;
            RTCP_SEL_P2HZ:  s_d.irq_low = !quarter[0];
            RTCP_SEL_P1HZ:  s_d.irq_low = !quarter[1];
            default:        s_d.irq_low = s_d.flag;
        endcase
        s_d.irq_low = s_d.irq_low || alarm_any;
        // The pin level is kept in its own flop so the output has no inverter.
        s_d.irq_n   = !s_d.irq_low;
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            s_q <= '{flag: 1'b0, sec_inc: 1'b0, irq_low: 1'b0, irq_n: 1'b1, sec20: 5'd0};
        end else begin
            s_q <= s_d;
        end
    end

    assign sec_inc             = s_q.sec_inc;
    assign periodic_event_flag = s_q.flag;
    assign irq_oe              = s_q.irq_low;
    assign irq_out_n           = s_q.irq_n;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);

    chk_off_high: assert property (
        (sel == RTCP_SEL_OFF) && !alarm_any |=> !irq_oe
    ) else $error("output driven while selection is off");

    chk_fixed_low: assert property (
        (sel == RTCP_SEL_FIXED) |=> irq_oe && !irq_out_n
    ) else $error("fixed-low selection did not drive the output");

    chk_pulse_2hz: assert property (
        (sel == RTCP_SEL_P2HZ) && !alarm_any |=> irq_oe == !$past(quarter[0])
    ) else $error("2 Hz waveform does not follow the quarter phase");

    chk_pulse_1hz: assert property (
        (sel == RTCP_SEL_P1HZ) && !alarm_any |=> irq_oe == !$past(quarter[1])
    ) else $error("1 Hz waveform does not follow the half-second phase");

    chk_level_event: assert property (
        wrap && is_level(sel) && level_ev |=> sec_inc && irq_oe && periodic_event_flag
    ) else $error("level event did not fall with the seconds increment");

    chk_minute_gate: assert property (
        (sel == RTCP_SEL_LMIN) && !periodic_event_flag && !sec_write && !next_sec_zero
        |=> !periodic_event_flag
    ) else $error("minute event raised away from second zero");

    chk_flag_hold: assert property (
        periodic_event_flag && !flag_clear |=> periodic_event_flag [*1]
    ) else $error("periodic flag dropped without a clear");

    chk_flag_clear: assert property (
        periodic_event_flag && flag_clear && !flag_set |=> !periodic_event_flag
    ) else $error("flag clear was not honoured");

    chk_pulse_inc: assert property (
        sec_inc && $past(is_pulse(sel)) |-> $past(cnt) == CNT_W'(INC_DELAY_CYC)
            && $past(quarter) == 2'd0
    ) else $error("pulse-mode increment not at the fixed delay after the fall");

    chk_write_restart: assert property (
        sec_write |=> cnt == '0 && quarter == 2'd0
    ) else $error("seconds write did not clear the divider");

    chk_adj_stretch: assert property (
        cnt > CNT_W'(QUARTER_CYC - 1) |-> quarter == 2'd0 && $past(adj_enable)
            && $past(adj_lengthen) && cnt <= CNT_W'(QUARTER_CYC + ADJ_CYC - 1)
    ) else $error("quarter stretched beyond the adjustment bound");

    chk_alarm_or: assert property (
        alarm_any |=> irq_oe
    ) else $error("alarm request not merged onto the output");

    cov_level_ack: cover property (
        is_level(sel) && periodic_event_flag ##1 flag_clear ##1 !periodic_event_flag
    );

    cov_pulse_inc: cover property (is_pulse(sel) && sec_inc);

    cov_adj_slot: cover property (adj_slot && wrap == 1'b0 ##1 adj_slot);

    cov_set_clear: cover property (flag_set && flag_clear);

endmodule : rtcp_periodic

`default_nettype wire

// file: rtcp_host_model.sv
`default_nettype none

module rtcp_host_model (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       srst,
    // Pin and service control
    input  wire logic       irq_pin,
    input  wire logic       ack_en,
    input  wire logic [7:0] ack_dly,
    // Host write of 0 to the periodic flag
    output logic            flag_clear
);
    timeunit 1ns;
    timeprecision 1ns;

    logic       clr_q  = 1'b0;
    logic [7:0] wait_q = 8'h00;

    assign flag_clear = clr_q;

    // The host answers a low pin only after its own latency; a fast host
    // would hide a design that releases the pin on its own.
    always @(posedge clock) begin
        clr_q <= 1'b0;
        if (srst || !ack_en || irq_pin) begin
            wait_q <= 8'h00;
        end else if (wait_q == ack_dly) begin
            clr_q  <= 1'b1;
            wait_q <= 8'h00;
        end else begin
            wait_q <= wait_q + 8'h01;
        end
    end
endmodule : rtcp_host_model

`default_nettype wire

// file: tb_rtc_periodic_interrupt_generator.sv
`default_nettype none

module tb_rtc_periodic_interrupt_generator;
    import rtcp_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int QC  = 40;
    localparam int IDC = 5;
    localparam int AC  = 4;
    localparam int SEC = 4 * QC;

    logic       clock      = 1'b0;
    logic       srst       = 1'b1;
    logic [2:0] period_sel = RTCP_SEL_OFF;
    logic [1:0] alarm_en   = 2'h0;
    logic [1:0] alarm_hit  = 2'h0;
    logic       sec_write  = 1'b0;
    logic [3:0] gates      = 4'h0;
    logic       adj_enable = 1'b0;
    logic       adj_len    = 1'b0;
    logic       ack_en     = 1'b1;
    logic [7:0] ack_dly    = 8'h02;
    wire logic  flag_clear, sec_inc, periodic_event_flag, irq_out_n, irq_oe, irq_pin;
    int         mismatches = 0;
    int         cmp_count  = 0;
    int         cycles     = 0;

    // The pin is open drain with a pull-up.
    assign irq_pin = irq_oe ? 1'b0 : 1'b1;

    always #5 clock = ~clock;

    rtcp_periodic #(.QUARTER_CYC(QC), .INC_DELAY_CYC(IDC), .ADJ_CYC(AC)) dut_u (
        .clock(clock), .srst(srst), .period_sel(period_sel),
        .weekly_alarm_enable(alarm_en[1]), .daily_alarm_enable(alarm_en[0]),
        .alarm_w_match(alarm_hit[1]), .alarm_d_match(alarm_hit[0]),
        .flag_clear(flag_clear), .sec_write(sec_write),
        .next_sec_zero(gates[0]), .next_min_zero(gates[1]),
        .next_hour_zero(gates[2]), .next_day_one(gates[3]),
        .adj_enable(adj_enable), .adj_lengthen(adj_len), .sec_inc(sec_inc),
        .periodic_event_flag(periodic_event_flag), .irq_out_n(irq_out_n), .irq_oe(irq_oe));

    rtcp_host_model host_u (.clock(clock), .srst(srst), .irq_pin(irq_pin),
        .ack_en(ack_en), .ack_dly(ack_dly), .flag_clear(flag_clear));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    // Everything is driven and sampled one nanosecond after the edge.
    task automatic step(input int n = 1);
        repeat (n) @(posedge clock);
        #1;
    endtask : step

    task automatic wait_inc(output int n);
        n = 0;
        do begin
            step();
            n++;
        end while (sec_inc !== 1'b1 && n < 400);
        check("increment seen", n < 400, 1);
    endtask : wait_inc

    task automatic watch(input int n, output int lows, output int falls, output int sets);
        logic prev;
        lows = 0;
        falls = 0;
        sets = 0;
        prev = irq_out_n;
        repeat (n) begin
            step();
            lows += (irq_out_n === 1'b0);
            falls += (prev === 1'b1 && irq_out_n === 1'b0);
            sets += (periodic_event_flag === 1'b1);
            prev = irq_out_n;
        end
    endtask : watch

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_static();
        int l, f, s;
        check("irq after reset", irq_out_n, 1'b1);
        check("flag after reset", periodic_event_flag, 1'b0);
        check("oe after reset", irq_oe, 1'b0);
        check("field place", {RTCP_CTRL1_OFFSET, 4'(RTCP_SEL_MSB)}, 8'hE2);
        watch(SEC + 8, l, f, s);
        check("off lows", l, 0);
        period_sel = RTCP_SEL_FIXED;
        step(2);
        watch(SEC, l, f, s);
        check("fixed lows", l, SEC);
        check("fixed oe", irq_oe, 1'b1);
    endtask : t_static

    task automatic t_alarm();
        period_sel = RTCP_SEL_OFF;
        step(4);
        for (int i = 0; i < 2; i++) begin
            alarm_hit[i] = 1'b1;
            step(2);
            check("alarm masked", irq_out_n, 1'b1);
            alarm_en[i] = 1'b1;
            step();
            check("alarm ored", irq_out_n, 1'b0);
            alarm_hit[i] = 1'b0;
            step(2);
            check("alarm gone", irq_out_n, 1'b1);
            alarm_en[i] = 1'b0;
        end
    endtask : t_alarm

    task automatic t_pulse(input logic [2:0] sel, input int exp_falls);
        int l, f, s, n;
        period_sel = sel;
        wait_inc(n);
        wait_inc(n);
        check("low at increment", irq_out_n, 1'b0);
        watch(SEC, l, f, s);
        check("pulse lows", l, SEC / 2);
        check("pulse falls", f, exp_falls);
    endtask : t_pulse

    task automatic t_secwrite();
        int n;
        period_sel = RTCP_SEL_P1HZ;
        wait_inc(n);
        step(SEC / 2);
        check("high before write", irq_out_n, 1'b1);
        sec_write = 1'b1;
        step();
        sec_write = 1'b0;
        step();
        check("low after write", irq_out_n, 1'b0);
        wait_inc(n);
        check("increment delay", n, IDC);
        period_sel = RTCP_SEL_LSEC;
        wait_inc(n);
        step(20);
        ack_en = 1'b0;
        sec_write = 1'b1;
        step();
        sec_write = 1'b0;
        check("level write flag", periodic_event_flag, 1'b1);
        check("level write pin", irq_out_n, 1'b0);
        ack_en = 1'b1;
        step(8);
    endtask : t_secwrite

    task automatic t_level();
        int l, f, s, n;
        ack_en = 1'b0;
        gates = 4'h0;
        wait_inc(n);
        check("fall at increment", irq_out_n, 1'b0);
        check("flag at event", periodic_event_flag, 1'b1);
        watch(SEC + 20, l, f, s);
        check("level held", l, SEC + 20);
        ack_en = 1'b1;
        step(ack_dly + 3);
        check("released", irq_out_n, 1'b1);
        check("flag cleared", periodic_event_flag, 1'b0);
    endtask : t_level

    task automatic t_gated();
        int l, f, s, n;
        ack_dly = 8'h08;
        for (int i = 0; i < 3; i++) begin
            period_sel = 3'(5 + i);
            wait_inc(n);
            gates = (i == 0) ? 4'hE : (i == 1) ? 4'hD : 4'h7;
            step(20);
            watch(2 * SEC, l, f, s);
            check("closed gate", s, 0);
            gates = 4'hF;
            watch(SEC + 8, l, f, s);
            check("open gate", s > 0, 1);
        end
    endtask : t_gated

    task automatic t_adjust(input logic [2:0] sel, input logic len);
        int n, odd, base;
        period_sel = sel;
        adj_enable = 1'b1;
        adj_len = len;
        odd = 0;
        base = 0;
        wait_inc(n);
        wait_inc(n);
        repeat (20) begin
            wait_inc(n);
            base += (n == SEC);
            odd += (n == (len ? SEC + AC : SEC - AC));
        end
        check("plain seconds", base, 19);
        check("adjusted seconds", odd, 1);
        adj_enable = 1'b0;
    endtask : t_adjust

    // ------------------------------------------------------------------
    // Sequence and verdict
    // ------------------------------------------------------------------
    task automatic tally_and_finish();
        if (mismatches == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : tally_and_finish

    // The ceiling is nearly three times the expected run length.
    always @(posedge clock) begin
        cycles++;
        if (cycles == 30000) begin
            mismatches++;
            tally_and_finish();
        end
    end

    initial begin
        step(10);
        srst = 1'b0;
        step();
        t_static();
        t_alarm();
        t_pulse(RTCP_SEL_P2HZ, 2);
        t_pulse(RTCP_SEL_P1HZ, 1);
        t_secwrite();
        t_level();
        t_gated();
        t_adjust(RTCP_SEL_P1HZ, 1'b1);
        t_adjust(RTCP_SEL_LSEC, 1'b0);
        tally_and_finish();
    end
endmodule : tb_rtc_periodic_interrupt_generator

`default_nettype wire
